// *** hw/clock_power_pkg.sv ***
// Constants, types and register map of the keyed clock and power control unit
// Function
// - Post-key 0x55 written right after the PLL source write commits the new source.
// - Pre-key 0xaa written right before the PLL source write opens the sequence.
// - Two-bit PLL reference select: low power, precision, crystal; 11 reserved.
// - PLL source register resets to zero, selecting the low power oscillator.
// - Pre-key 0x01 written right before the power control write opens the sequence.
// - Post-key 0xf4 written right after the power control write commits it.
// - Core clock is the PLL clock divided by two to the divider field.
// - Bit 7 clear powers down the precision oscillator input; set enables it.
// - Bit 6 clear powers down crystal circuitry; set enables it.
// - PLL off powers down PLL-clocked timers; other timers keep running.
// - PLL stays powered while core or peripherals enabled; clear 3, 4, 5 together.
// - Bit 4 clear powers down SRAM, flash, GPIO, SPI and UART.
// - Peripherals stay powered while core enabled; clear bits 3 and 4 together.
// - With peripherals down, LIN wake-up still works; low power wake-up timer runs.
// - Bits 3, 4, 5 set at reset and set again by any wake-up event.
// - Bit 3 clear powers down the core; software adds one dummy cycle.
package clock_power_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] POWER_PREKEY_ADDR  = 32'hffff0404;
  localparam logic [31:0] POWER_CTRL_ADDR    = 32'hffff0408;
  localparam logic [31:0] POWER_POSTKEY_ADDR = 32'hffff040c;
  localparam logic [31:0] PLL_PREKEY_ADDR    = 32'hffff0410;
  localparam logic [31:0] PLL_SRC_ADDR       = 32'hffff0414;
  localparam logic [31:0] PLL_POSTKEY_ADDR   = 32'hffff0418;

  localparam logic [31:0] POWER_PREKEY  = 32'h00000001;
  localparam logic [31:0] POWER_POSTKEY = 32'h000000f4;
  localparam logic [31:0] PLL_PREKEY    = 32'h000000aa;
  localparam logic [31:0] PLL_POSTKEY   = 32'h00000055;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] POWER_RESET = 8'h79;
  localparam logic [1:0] PLL_RESET   = 2'h0;
  localparam int         BIT_CORE    = 3;
  localparam int         BIT_PERIPH  = 4;
  localparam int         BIT_PLL     = 5;
  localparam int         BIT_CRYSTAL_CIRCUITRY    = 6;
  localparam int         BIT_PREC    = 7;
  localparam logic [7:0] WAKE_MASK   = 8'h38;
  localparam logic [1:0] SRC_LOW_POWER = 2'h0;
  localparam logic [1:0] SRC_PRECISION = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL   = 2'h2;
  localparam logic [1:0] SRC_RESERVED  = 2'h3;
  localparam logic [3:0] FULL_WORD     = 4'hf;
  localparam logic [31:0] READ_ZERO    = 32'h00000000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } av_rsp_t;

  typedef struct packed {
    logic [1:0] pll_ref_sel;
    logic [2:0] core_clock_divider;
    logic       core_run;
    logic       periph_run;
    logic       pll_run;
    logic       pll_timer_run;
    logic       crystal_circuitry_run;
    logic       precision_input_run;
    logic       lin_wake_armed;
    logic       wakeup_timer_run;
  } power_out_t;

  typedef enum logic [2:0] {
    KEY_IDLE,
    KEY_PLL_OPEN,
    KEY_PLL_HELD,
    KEY_POW_OPEN,
    KEY_POW_HELD
  } key_state_t;

  // Divider terminal count for a core clock of base rate over 2**cd
  function automatic logic [6:0] div_limit(input logic [2:0] cd);
    div_limit = 7'(({7'h00, 1'b1} << cd) - 8'h01);
  endfunction : div_limit

endpackage : clock_power_pkg

// *** hw/keyed_clock_power_control.sv ***
// Keyed clock source and power control unit with an Avalon-MM slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module keyed_clock_power_control (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire clock_power_pkg::av_req_t av_req,
  output      clock_power_pkg::av_rsp_t av_rsp,
  input  wire logic                    wake_event,
  input  wire logic                    wakeup_timer_on_lp_osc,
  output      clock_power_pkg::power_out_t power_out,
  output      logic                    core_clock_tick
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Wake-up pin synchroniser
  // ----------------------------------------------------------------------
  logic wake_meta_q;
  logic wake_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_meta_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      wake_meta_q <= wake_event;
      wake_q      <= wake_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // One wait cycle per access; the access takes effect on the edge where
  // waitrequest is seen low, and read data stand at that same edge.
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_acc;
  logic [1:0]  src_q;
  logic [1:0]  src_d;
  logic [7:0]  power_q;
  logic [7:0]  power_d;

  assign wr_acc = av_req.write && !wait_q;

  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((av_req.read || av_req.write) && wait_q) begin
      wait_d = 1'b0;
    end
    if (av_req.read && wait_q) begin
      // Key locations are write only and read back as zero
      case (av_req.address)
        clock_power_pkg::PLL_SRC_ADDR:    rdata_d = {30'h00000000, src_q};
        clock_power_pkg::POWER_CTRL_ADDR: rdata_d = {24'h000000, power_q};
        default:                          rdata_d = clock_power_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign av_rsp.waitrequest = wait_q;
  assign av_rsp.readdata    = rdata_q;

  // ----------------------------------------------------------------------
  // Key sequencer and protected registers
  // ----------------------------------------------------------------------
  // Any accepted write that breaks the key order drops the sequence. Reads
  // do not disturb it, so a debugger may look at the registers in between.
  clock_power_pkg::key_state_t state_q;
  clock_power_pkg::key_state_t state_d;
  logic [7:0] held_q;
  logic [7:0] held_d;
  logic [7:0] want;
  logic       full_word;
  logic       lane0;

  assign full_word = (av_req.byteenable == clock_power_pkg::FULL_WORD);
  assign lane0     = av_req.byteenable[0];

  always_comb begin
    state_d = state_q;
    held_d  = held_q;
    src_d   = src_q;
    power_d = power_q;
    want    = held_q;
    if (wr_acc) begin
      state_d = clock_power_pkg::KEY_IDLE;
      case (state_q)
        clock_power_pkg::KEY_PLL_OPEN: begin
          if (av_req.address == clock_power_pkg::PLL_SRC_ADDR && lane0) begin
            state_d = clock_power_pkg::KEY_PLL_HELD;
            held_d  = av_req.writedata[7:0];
          end
        end
        clock_power_pkg::KEY_PLL_HELD: begin
          if (av_req.address == clock_power_pkg::PLL_POSTKEY_ADDR && full_word &&
              av_req.writedata == clock_power_pkg::PLL_POSTKEY) begin
            // Reserved code leaves the current reference in place
            if (held_q[1:0] != clock_power_pkg::SRC_RESERVED) begin
              src_d = held_q[1:0];
            end
          end
        end
        clock_power_pkg::KEY_POW_OPEN: begin
          if (av_req.address == clock_power_pkg::POWER_CTRL_ADDR && lane0) begin
            state_d = clock_power_pkg::KEY_POW_HELD;
            held_d  = av_req.writedata[7:0];
          end
        end
        clock_power_pkg::KEY_POW_HELD: begin
          if (av_req.address == clock_power_pkg::POWER_POSTKEY_ADDR && full_word &&
              av_req.writedata == clock_power_pkg::POWER_POSTKEY) begin
            want = held_q;
            if (want[clock_power_pkg::BIT_CORE]) begin
              want[clock_power_pkg::BIT_PERIPH] = 1'b1;
            end
            if (want[clock_power_pkg::BIT_CORE] || want[clock_power_pkg::BIT_PERIPH]) begin
              want[clock_power_pkg::BIT_PLL] = 1'b1;
            end
            power_d = want;
          end
        end
        default: begin
        end
      endcase
      // A fresh prewrite key always restarts a sequence
      if (full_word && av_req.address == clock_power_pkg::PLL_PREKEY_ADDR &&
          av_req.writedata == clock_power_pkg::PLL_PREKEY) begin
        state_d = clock_power_pkg::KEY_PLL_OPEN;
      end
      if (full_word && av_req.address == clock_power_pkg::POWER_PREKEY_ADDR &&
          av_req.writedata == clock_power_pkg::POWER_PREKEY) begin
        state_d = clock_power_pkg::KEY_POW_OPEN;
      end
    end
    // Wake-up wins over a commit in the same cycle
    if (wake_q) begin
      power_d = power_d | clock_power_pkg::WAKE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= clock_power_pkg::KEY_IDLE;
      held_q  <= 8'h00;
      src_q   <= clock_power_pkg::PLL_RESET;
      power_q <= clock_power_pkg::POWER_RESET;
    end else begin
      state_q <= state_d;
      held_q  <= held_d;
      src_q   <= src_d;
      power_q <= power_d;
    end
  end

  // ----------------------------------------------------------------------
  // Core clock divider
  // ----------------------------------------------------------------------
  // clk stands for the PLL output; the core clock is an enable pulse.
  logic [6:0] div_cnt_q;
  logic [6:0] div_cnt_d;
  logic       tick_q;
  logic       tick_d;
  logic [6:0] limit;

  assign limit = clock_power_pkg::div_limit(power_q[2:0]);

  always_comb begin
    div_cnt_d = div_cnt_q + 7'h01;
    tick_d    = 1'b0;
    if (!power_q[clock_power_pkg::BIT_CORE]) begin
      div_cnt_d = 7'h00;
    end else if (div_cnt_q >= limit) begin
      div_cnt_d = 7'h00;
      tick_d    = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt_q <= 7'h00;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
    end
  end

  assign core_clock_tick = tick_q;

  // ----------------------------------------------------------------------
  // Power and clock outputs
  // ----------------------------------------------------------------------
  // Outputs follow the registers one cycle late so that all leave a flop.
  clock_power_pkg::power_out_t out_q;
  clock_power_pkg::power_out_t out_d;

  always_comb begin
    out_d.pll_ref_sel           = src_q;
    out_d.core_clock_divider    = power_q[2:0];
    out_d.core_run              = power_q[clock_power_pkg::BIT_CORE];
    out_d.periph_run            = power_q[clock_power_pkg::BIT_PERIPH];
    out_d.pll_run               = power_q[clock_power_pkg::BIT_PLL];
    out_d.pll_timer_run         = power_q[clock_power_pkg::BIT_PLL];
    out_d.crystal_circuitry_run = power_q[clock_power_pkg::BIT_CRYSTAL_CIRCUITRY];
    out_d.precision_input_run   = power_q[clock_power_pkg::BIT_PREC];
    out_d.lin_wake_armed        = !power_q[clock_power_pkg::BIT_PERIPH];
    out_d.wakeup_timer_run      = power_q[clock_power_pkg::BIT_PERIPH] ||
                                  wakeup_timer_on_lp_osc;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_q <= '{pll_ref_sel: clock_power_pkg::SRC_LOW_POWER, core_clock_divider: 3'h1,
                 core_run: 1'b1, periph_run: 1'b1, pll_run: 1'b1, pll_timer_run: 1'b1,
                 crystal_circuitry_run: 1'b1, precision_input_run: 1'b0,
                 lin_wake_armed: 1'b0, wakeup_timer_run: 1'b1};
    end else begin
      out_q <= out_d;
    end
  end

  assign power_out = out_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_reset_values: assert property (@(posedge clk)
    $rose(rst_sync_n) |-> (src_q == clock_power_pkg::PLL_RESET &&
                           power_q == clock_power_pkg::POWER_RESET))
    else $error("reset values wrong");

  chk_pll_commit_key: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $changed(src_q) |-> $past(state_q == clock_power_pkg::KEY_PLL_HELD && wr_acc &&
                              av_req.address == clock_power_pkg::PLL_POSTKEY_ADDR))
    else $error("PLL source changed without postwrite key");

  chk_pll_open_order: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == clock_power_pkg::KEY_PLL_HELD && $changed(state_q)) |->
      $past(state_q) == clock_power_pkg::KEY_PLL_OPEN)
    else $error("PLL source held without prewrite key");

  chk_src_reserved: assert property (@(posedge clk) disable iff (!rst_sync_n)
    src_q != clock_power_pkg::SRC_RESERVED)
    else $error("reserved PLL source selected");

  chk_power_interlock: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (power_q[clock_power_pkg::BIT_CORE] |-> power_q[clock_power_pkg::BIT_PERIPH]) and
    (power_q[clock_power_pkg::BIT_PERIPH] |-> power_q[clock_power_pkg::BIT_PLL]))
    else $error("power interlock broken");

  chk_power_commit: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ($changed(power_q) && !$past(wake_q)) |->
      $past(state_q == clock_power_pkg::KEY_POW_HELD && wr_acc &&
            av_req.address == clock_power_pkg::POWER_POSTKEY_ADDR))
    else $error("power control changed without keys");

  chk_wake_sets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wake_q |=> ((power_q & clock_power_pkg::WAKE_MASK) == clock_power_pkg::WAKE_MASK))
    else $error("wake-up did not set enables");

  chk_div_period: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ((power_q[2:0] == 3'h2 && power_q[clock_power_pkg::BIT_CORE]) [*6] ##0 tick_q) |->
      ($past(tick_q, 4) && !$past(tick_q, 1) && !$past(tick_q, 2)))
    else $error("core tick period wrong");

  chk_core_off_tick: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !power_q[clock_power_pkg::BIT_CORE] |=> !tick_q)
    else $error("core tick while core off");

  chk_bus_answer: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ((av_req.read || av_req.write) && wait_q) |=> !wait_q ##1 wait_q)
    else $error("bus answer timing wrong");

  chk_pow_open_order: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == clock_power_pkg::KEY_POW_HELD && $changed(state_q)) |->
      $past(state_q) == clock_power_pkg::KEY_POW_OPEN)
    else $error("power control held without prewrite key");

  chk_ref_follow: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.pll_ref_sel == $past(src_q))
    else $error("PLL reference output wrong");

  chk_div_field_out: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.core_clock_divider == $past(power_q[2:0]))
    else $error("divider output wrong");

  chk_prec_input: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.precision_input_run == $past(power_q[clock_power_pkg::BIT_PREC]))
    else $error("precision input enable wrong");

  chk_crystal_circuitry_follow: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.crystal_circuitry_run == $past(power_q[clock_power_pkg::BIT_CRYSTAL_CIRCUITRY]))
    else $error("crystal enable wrong");

  chk_pll_timer: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.pll_timer_run == $past(power_q[clock_power_pkg::BIT_PLL]) &&
    power_out.pll_run == $past(power_q[clock_power_pkg::BIT_PLL]))
    else $error("PLL or PLL timer enable wrong");

  chk_periph_out: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.periph_run == $past(power_q[clock_power_pkg::BIT_PERIPH]))
    else $error("peripheral enable wrong");

  chk_lin_wake: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.lin_wake_armed == !$past(power_q[clock_power_pkg::BIT_PERIPH]))
    else $error("LIN wake-up arming wrong");

  chk_timer_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.wakeup_timer_run == ($past(power_q[clock_power_pkg::BIT_PERIPH]) ||
                                   $past(wakeup_timer_on_lp_osc)))
    else $error("wake-up timer enable wrong");

  chk_core_out: assert property (@(posedge clk) disable iff (!rst_sync_n)
    power_out.core_run == $past(power_q[clock_power_pkg::BIT_CORE]))
    else $error("core enable output wrong");

  chk_read_source: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (av_req.read && wait_q && av_req.address == clock_power_pkg::PLL_SRC_ADDR) |=>
      av_rsp.readdata == {30'h00000000, $past(src_q)})
    else $error("PLL source read back wrong");

endmodule : keyed_clock_power_control

// *** sim/testbench.sv ***
// Self-checking testbench for the keyed clock and power control unit
`timescale 1ns/100ps
module testbench;
  // --------------------------------------------------------------------
  // Signals and design instance
  // --------------------------------------------------------------------
  logic                          clk;
  logic                          rst_n;
  clock_power_pkg::av_req_t      av_req;
  clock_power_pkg::av_rsp_t      av_rsp;
  logic                          wake_event;
  logic                          wakeup_timer_on_lp_osc;
  clock_power_pkg::power_out_t   power_out;
  logic                          core_clock_tick;
  int                            errors;
  int                            tests_run;
  int                            n;
  logic [1:0]                    src;
  logic [1:0]                    codes [4];

  keyed_clock_power_control i_keyed_clock_power_control (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .av_req                 (av_req),
    .av_rsp                 (av_rsp),
    .wake_event             (wake_event),
    .wakeup_timer_on_lp_osc (wakeup_timer_on_lp_osc),
    .power_out              (power_out),
    .core_clock_tick        (core_clock_tick)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // Holds the request until waitrequest is sampled low; takes read data at that edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    av_req <= '{read: ~wr, write: wr, address: a, byteenable: 4'hf, writedata: d};
    do begin
      @(posedge clk);
      k++;
    end while (av_rsp.waitrequest !== 1'b0 && k < 50);
    check_val("bus answer", 32'h0, 32'(k >= 50));
    q = av_rsp.readdata;
    av_req <= '0;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_val(what, exp, q);
  endtask : rd

  task automatic pll_write(input logic [31:0] d);
    wr(clock_power_pkg::PLL_PREKEY_ADDR, clock_power_pkg::PLL_PREKEY);
    wr(clock_power_pkg::PLL_SRC_ADDR, d);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    @(posedge clk);
  endtask : pll_write

  task automatic pow_write(input logic [31:0] d);
    wr(clock_power_pkg::POWER_PREKEY_ADDR, clock_power_pkg::POWER_PREKEY);
    wr(clock_power_pkg::POWER_CTRL_ADDR, d);
    wr(clock_power_pkg::POWER_POSTKEY_ADDR, clock_power_pkg::POWER_POSTKEY);
    @(posedge clk);
  endtask : pow_write

  // Outputs lag the register by a cycle, so let them settle before comparing
  task automatic out_check(input logic [7:0] pc);
    clock_power_pkg::power_out_t e;
    // Settle first: the timer source input may have just been changed
    repeat (3) @(posedge clk);
    e = '{pll_ref_sel: src, core_clock_divider: pc[2:0], core_run: pc[3],
          periph_run: pc[4], pll_run: pc[5], pll_timer_run: pc[5],
          crystal_circuitry_run: pc[6], precision_input_run: pc[7],
          lin_wake_armed: ~pc[4], wakeup_timer_run: pc[4] | wakeup_timer_on_lp_osc};
    check_val("power_out", 32'(e), 32'(power_out));
  endtask : out_check

  task automatic ticks(input int cycles, input int exp);
    int c;
    c = 0;
    repeat (4) @(posedge clk);
    repeat (cycles) begin
      @(posedge clk);
      if (core_clock_tick === 1'b1) c++;
    end
    check_val("tick count", 32'(exp), 32'(c));
  endtask : ticks

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    av_req = '0;
    wake_event = 1'b0;
    wakeup_timer_on_lp_osc = 1'b1;
    errors = 0;
    tests_run = 0;
    src = 2'h0;
    codes = '{2'h1, 2'h2, 2'h3, 2'h0};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);

    rd("power_control", clock_power_pkg::POWER_CTRL_ADDR, 32'h00000079);
    rd("pll_source", clock_power_pkg::PLL_SRC_ADDR, 32'h00000000);
    rd("key read", clock_power_pkg::POWER_PREKEY_ADDR, 32'h0);
    rd("key read", clock_power_pkg::POWER_POSTKEY_ADDR, 32'h0);
    rd("key read", clock_power_pkg::PLL_PREKEY_ADDR, 32'h0);
    rd("key read", clock_power_pkg::PLL_POSTKEY_ADDR, 32'h0);
    rd("unmapped read", 32'hffff0500, 32'h0);
    out_check(8'h79);
    $display("test reset done");

    foreach (codes[i]) begin
      pll_write({30'h0, codes[i]});
      if (codes[i] != 2'h3) src = codes[i];
      rd("pll_source", clock_power_pkg::PLL_SRC_ADDR, {30'h0, src});
      out_check(8'h79);
    end
    $display("test pll source done");

    wr(clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("no prekey", clock_power_pkg::PLL_SRC_ADDR, 32'h0);
    wr(clock_power_pkg::PLL_PREKEY_ADDR, clock_power_pkg::PLL_PREKEY);
    wr(32'hffff0500, 32'h0);
    wr(clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("foreign between", clock_power_pkg::PLL_SRC_ADDR, 32'h0);
    wr(clock_power_pkg::PLL_PREKEY_ADDR, clock_power_pkg::PLL_PREKEY);
    wr(clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, 32'h00000056);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("wrong postkey", clock_power_pkg::PLL_SRC_ADDR, 32'h0);
    wr(clock_power_pkg::POWER_PREKEY_ADDR, clock_power_pkg::POWER_PREKEY);
    wr(clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("wrong prekey", clock_power_pkg::PLL_SRC_ADDR, 32'h0);
    wr(clock_power_pkg::POWER_PREKEY_ADDR, clock_power_pkg::POWER_PREKEY);
    wr(clock_power_pkg::POWER_CTRL_ADDR, 32'h78);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("mixed keys", clock_power_pkg::POWER_CTRL_ADDR, 32'h79);
    wr(clock_power_pkg::PLL_PREKEY_ADDR, clock_power_pkg::PLL_PREKEY);
    wr(clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    rd("read between", clock_power_pkg::PLL_SRC_ADDR, 32'h0);
    wr(clock_power_pkg::PLL_POSTKEY_ADDR, clock_power_pkg::PLL_POSTKEY);
    rd("read between", clock_power_pkg::PLL_SRC_ADDR, 32'h1);
    src = 2'h1;
    $display("test key sequence done");

    for (int cd = 0; cd < 8; cd += 2) begin
      pow_write({24'h0, 5'h0f, 3'(cd)});
      rd("divider", clock_power_pkg::POWER_CTRL_ADDR, {24'h0, 5'h0f, 3'(cd)});
      ticks(128, 128 >> cd);
    end
    pow_write(32'hb9);
    out_check(8'hb9);
    rd("osc enables", clock_power_pkg::POWER_CTRL_ADDR, 32'hb9);
    $display("test divider done");

    pow_write(32'h68);
    rd("core keeps periph", clock_power_pkg::POWER_CTRL_ADDR, 32'h78);
    pow_write(32'h50);
    rd("periph keeps pll", clock_power_pkg::POWER_CTRL_ADDR, 32'h70);
    out_check(8'h70);
    pow_write(32'h40);
    rd("full off", clock_power_pkg::POWER_CTRL_ADDR, 32'h40);
    out_check(8'h40);
    ticks(32, 0);
    wakeup_timer_on_lp_osc <= 1'b0;
    out_check(8'h40);
    $display("test interlock done");

    wake_event <= 1'b1;
    repeat (8) @(posedge clk);
    wake_event <= 1'b0;
    rd("wake", clock_power_pkg::POWER_CTRL_ADDR, 32'h78);
    out_check(8'h78);
    ticks(32, 32);
    $display("test wake done");
    print_verdict();
  end

  // Cuts a hang short; the tests need under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[FAIL] watchdog expected done seen timeout");
    print_verdict();
  end
endmodule : testbench
